/* src/poa_top.sv */
// power-on acknowledge, boot selector latch and reset domains with apb registers
// Function
// (RQ1) reset out held until power-up sequence ends
// (RQ2) on request starts power-up, active releases reset
// (RQ3) hold mode: eight second window then shutdown
// (RQ4) host holds the hold pin high
// (RQ5) hold pin falling edge is off request
// (RQ6) auto mode sets keep-on bit at end
// (RQ7) keep-on bit may replace the hold pin
// (RQ8) host keeps keep-on bit at one
// (RQ9) sequences are register writes, software overwrites
// (RQ10) selector picks program half and branch
// (RQ11) selector latched at power-up end, readable
// (RQ12) selector branches steps during sequence
// (RQ13) power-on reset clears all three domains
// (RQ14) power-on domain survives hardware and switch-off
// (RQ15) fault, mask and cause registers power-on only
// (RQ16) hard level off runs matching off sequence
// (RQ17) hard reset clears hardware and switch-off domains
// (RQ18) soft level off clears switch-off domain only
// (RQ19) hardware domain holds interrupt and boot state
// (RQ20) switch-off domain holds device control, enables
// (RQ21) levels coded 0 power-on, 1 hard, 2 switch-off
// (RQ22) interrupt output push-pull, low when pending
// (RQ23) interrupt masked in sleep, per-source masks
// (RQ24) warm restart reruns power-up, ends active
// (RQ25) widest requested reset level wins
// (RQ26) hold timer cleared in off, counts when active
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "poa_defs.svh"

module poa_top
#(
  parameter int unsigned HOLD_CYCLES = `POA_HOLD_WINDOW_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic on_request,
  input wire logic hold_request_pin,
  input wire logic warm_restart_pin_n,
  input wire logic sleep_request,
  input wire logic boot_select_pin,
  input wire logic thermal_event,
  input wire logic short_event,
  output logic system_reset_out,
  output logic int_n,
  output logic [`POA_RES_W-1:0] resource_enable
);

  // ****************************************
  // address decode
  // ****************************************
  function automatic poa_pkg::poa_reg_t poa_decode(input logic [7:0] a);
    case (a)
      `POA_OFF_DEVICE_CONTROL_REGISTER: poa_decode = poa_pkg::POA_R_DEVICE_CONTROL_REGISTER;
      `POA_OFF_CONFIG: poa_decode = poa_pkg::POA_R_CONFIG;
      `POA_OFF_BOOT_STATUS: poa_decode = poa_pkg::POA_R_BOOT;
      `POA_OFF_STATE: poa_decode = poa_pkg::POA_R_STATE;
      `POA_OFF_SWOFF_CAUSE: poa_decode = poa_pkg::POA_R_CAUSE;
      `POA_OFF_FAULT_STATUS: poa_decode = poa_pkg::POA_R_FAULT;
      `POA_OFF_PG_MASK: poa_decode = poa_pkg::POA_R_PG_MASK;
      `POA_OFF_INT_STATUS: poa_decode = poa_pkg::POA_R_INT_STATUS;
      `POA_OFF_INT_MASK: poa_decode = poa_pkg::POA_R_INT_MASK;
      `POA_OFF_RES_EN: poa_decode = poa_pkg::POA_R_RES_EN;
      default: poa_decode = poa_pkg::POA_R_NONE;
    endcase
  endfunction : poa_decode

  poa_pkg::poa_state_t state, next_state;
  poa_pkg::poa_lvl_t off_lvl, next_off_lvl;
  logic [27:0] hold_timer, next_hold_timer;
  logic keep_prev;
  logic warm_prev;
  logic seq_start, seq_dir_down, seq_busy, seq_done, seq_wr_valid, seq_wr_value;
  logic [2:0] seq_wr_index;
  // power-on domain
  logic [3:0] config_bits, next_config_bits;
  logic [3:0] swoff_cause, next_swoff_cause;
  logic [1:0] fault_status, next_fault_status;
  logic [7:0] pg_mask, next_pg_mask;
  // hardware domain
  logic [`POA_INT_W-1:0] int_status, next_int_status;
  logic [`POA_INT_W-1:0] int_mask, next_int_mask;
  logic boot_status, next_boot_status;
  // switch-off domain
  logic keep_on_bit, next_keep_on_bit;
  logic [`POA_RES_W-1:0] next_resource_enable;
  // bus
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic next_reset_out, next_int_n;

  logic apb_wr, apb_rd;
  poa_pkg::poa_reg_t wr_sel;
  logic keep_src, keep_fall, warm_fall, hold_expired;
  logic off_req, hw_clr, swo_clr, up_done;
  logic [3:0] cause_set;
  logic [`POA_INT_W-1:0] int_set;

  assign apb_wr = psel & penable & pready & pwrite;
  assign apb_rd = psel & penable & ~pready & ~pwrite;
  assign wr_sel = apb_wr ? poa_decode(paddr) : poa_pkg::POA_R_NONE;

  // ****************************************
  // off requests and timers
  // ****************************************
  // (RQ7) bit stands in for the pin
  assign keep_src = config_bits[`POA_CFG_KEEPON_MODE] ? keep_on_bit : hold_request_pin;
  // (RQ5) falling keep source
  assign keep_fall = keep_prev & ~keep_src;
  assign warm_fall = warm_prev & ~warm_restart_pin_n;
  assign hold_expired = (hold_timer == 28'(HOLD_CYCLES));
  assign up_done = (state == poa_pkg::POA_S_UP) & seq_done;
  assign cause_set[`POA_CAUSE_HOLD] = keep_fall & ~config_bits[`POA_CFG_KEEPON_MODE];
  assign cause_set[`POA_CAUSE_KEEPON] = keep_fall & config_bits[`POA_CFG_KEEPON_MODE];
  // (RQ3) window ends without keep source
  assign cause_set[`POA_CAUSE_TIMEOUT] = hold_expired & ~keep_src;
  assign cause_set[`POA_CAUSE_THERMAL] = thermal_event;
  assign off_req = |cause_set;
  // (RQ17) hard clear at end of down sequence
  assign hw_clr = (state == poa_pkg::POA_S_DOWN) & seq_done & (off_lvl == poa_pkg::POA_LVL_HW);
  // (RQ18) every off clears switch-off domain
  assign swo_clr = (state == poa_pkg::POA_S_DOWN) & seq_done;

  // ****************************************
  // power state machine
  // ****************************************
  // warm restart outranks off so a locked host can always recover
  always_comb
  begin
    next_state = state;
    next_off_lvl = off_lvl;
    seq_start = 1'b0;
    seq_dir_down = 1'b0;
    next_hold_timer = hold_timer;
    case (state)
      poa_pkg::POA_S_OFF:
      begin
        // (RQ2) on request starts power-up
        if (on_request)
        begin
          next_state = poa_pkg::POA_S_UP;
          seq_start = 1'b1;
        end
      end
      poa_pkg::POA_S_UP:
      begin
        if (seq_done)
          next_state = poa_pkg::POA_S_ACTIVE;
      end
      poa_pkg::POA_S_ACTIVE, poa_pkg::POA_S_SLEEP:
      begin
        if (warm_fall)
        begin
          // (RQ24) warm restart reruns power-up
          next_state = poa_pkg::POA_S_UP;
          seq_start = 1'b1;
        end
        else if (off_req)
        begin
          // (RQ16) off runs the down sequence
          next_state = poa_pkg::POA_S_DOWN;
          seq_start = 1'b1;
          seq_dir_down = 1'b1;
          // (RQ25) widest level wins
          next_off_lvl = (thermal_event | config_bits[`POA_CFG_OFF_HARD]) ?
                         poa_pkg::POA_LVL_HW : poa_pkg::POA_LVL_SWO;
        end
        else if (state == poa_pkg::POA_S_ACTIVE && sleep_request)
          next_state = poa_pkg::POA_S_SLEEP;
        else if (state == poa_pkg::POA_S_SLEEP && !sleep_request)
          next_state = poa_pkg::POA_S_ACTIVE;
      end
      poa_pkg::POA_S_DOWN:
      begin
        if (seq_done)
          next_state = poa_pkg::POA_S_OFF;
      end
      default: next_state = poa_pkg::POA_S_OFF;
    endcase
    // (RQ26) cleared in off, counts while active
    if (state == poa_pkg::POA_S_OFF)
      next_hold_timer = 28'h0;
    else if (state == poa_pkg::POA_S_ACTIVE && !hold_expired)
      next_hold_timer = hold_timer + 28'h1;
  end

  // (RQ1) reset out follows the registered active states only
  assign next_reset_out = (next_state == poa_pkg::POA_S_ACTIVE) | (next_state == poa_pkg::POA_S_SLEEP);

  // (RQ13) power-on reset is the asynchronous reset of every flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= poa_pkg::POA_S_OFF;
      off_lvl <= poa_pkg::POA_LVL_POR;
      hold_timer <= 28'h0;
      keep_prev <= 1'b0;
      warm_prev <= 1'b1;
      system_reset_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      off_lvl <= next_off_lvl;
      hold_timer <= next_hold_timer;
      keep_prev <= keep_src;
      warm_prev <= warm_restart_pin_n;
      system_reset_out <= next_reset_out;
    end
  end

  // ****************************************
  // sequence player
  // ****************************************
  // (RQ12) selector feeds the player every step
  poa_seq_runner u_runner
  (
    .clk(clk),
    .rst(rst),
    .start(seq_start),
    .dir_down(seq_dir_down),
    .sel(boot_select_pin),
    .busy(seq_busy),
    .done(seq_done),
    .wr_valid(seq_wr_valid),
    .wr_index(seq_wr_index),
    .wr_value(seq_wr_value)
  );

  // ****************************************
  // domain registers
  // ****************************************
  assign int_set[`POA_INT_THERMAL] = thermal_event;
  assign int_set[`POA_INT_SHORT] = short_event;
  assign int_set[`POA_INT_SEQ_DONE] = up_done;

  // hardware sets win over software clears
  always_comb
  begin
    // (RQ14) power-on domain ignores hard and switch-off clears
    next_config_bits = (wr_sel == poa_pkg::POA_R_CONFIG) ? pwdata[3:0] : config_bits;
    next_pg_mask = (wr_sel == poa_pkg::POA_R_PG_MASK) ? pwdata[7:0] : pg_mask;
    next_swoff_cause = ((wr_sel == poa_pkg::POA_R_CAUSE) ? swoff_cause & ~pwdata[3:0] : swoff_cause)
                       | ((state == poa_pkg::POA_S_ACTIVE || state == poa_pkg::POA_S_SLEEP) && !warm_fall ?
                          cause_set : 4'h0);
    next_fault_status = ((wr_sel == poa_pkg::POA_R_FAULT) ? fault_status & ~pwdata[1:0] : fault_status)
                        | {short_event, thermal_event};
    next_int_status = ((wr_sel == poa_pkg::POA_R_INT_STATUS) ? int_status & ~pwdata[`POA_INT_W-1:0] : int_status)
                      | int_set;
    next_int_mask = (wr_sel == poa_pkg::POA_R_INT_MASK) ? pwdata[`POA_INT_W-1:0] : int_mask;
    // (RQ11) selector latched at power-up end
    next_boot_status = up_done ? boot_select_pin : boot_status;
    next_keep_on_bit = (wr_sel == poa_pkg::POA_R_DEVICE_CONTROL_REGISTER) ? pwdata[0] : keep_on_bit;
    // (RQ6) auto mode sets the keep-on bit
    if (up_done && config_bits[`POA_CFG_KEEPON_MODE] && config_bits[`POA_CFG_AUTO_SET])
      next_keep_on_bit = 1'b1;
    // (RQ9) software may overwrite sequence results
    next_resource_enable = (wr_sel == poa_pkg::POA_R_RES_EN) ? pwdata[`POA_RES_W-1:0] : resource_enable;
    if (seq_wr_valid)
      next_resource_enable[seq_wr_index] = seq_wr_value;
    // (RQ19) hardware domain clear
    if (hw_clr)
    begin
      next_int_status = int_set;
      next_int_mask = {`POA_INT_W{1'b0}};
      next_boot_status = 1'b0;
    end
    // (RQ20) switch-off domain clear, in the same cycle as the last down sequence write
    if (swo_clr)
    begin
      next_keep_on_bit = 1'b0;
      next_resource_enable = {`POA_RES_W{1'b0}};
    end
  end

  // (RQ23) sleep masking and per-source masks
  assign next_int_n = ~((|(next_int_status & ~next_int_mask)) &
                        ~((next_state == poa_pkg::POA_S_SLEEP) & next_config_bits[`POA_CFG_SLEEP_MASK]));

  // (RQ15) power-on domain registers cleared only here
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      config_bits <= `POA_CONFIG_RST;
      swoff_cause <= 4'h0;
      fault_status <= 2'h0;
      pg_mask <= 8'h00;
      int_status <= {`POA_INT_W{1'b0}};
      int_mask <= {`POA_INT_W{1'b0}};
      boot_status <= 1'b0;
      keep_on_bit <= 1'b0;
      resource_enable <= {`POA_RES_W{1'b0}};
      int_n <= 1'b1;
    end
    else
    begin
      config_bits <= next_config_bits;
      swoff_cause <= next_swoff_cause;
      fault_status <= next_fault_status;
      pg_mask <= next_pg_mask;
      int_status <= next_int_status;
      int_mask <= next_int_mask;
      boot_status <= next_boot_status;
      keep_on_bit <= next_keep_on_bit;
      resource_enable <= next_resource_enable;
      // (RQ22) push-pull, low while pending
      int_n <= next_int_n;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  // one wait state: data and pready are both registered, so outputs stay glitch free
  always_comb
  begin
    next_pready = psel & penable & ~pready;
    next_pslverr = 1'b0;
    next_prdata = 32'h0;
    if (next_pready)
      next_pslverr = (poa_decode(paddr) == poa_pkg::POA_R_NONE);
    if (apb_rd)
    begin
      case (poa_decode(paddr))
        poa_pkg::POA_R_DEVICE_CONTROL_REGISTER: next_prdata = {31'h0, keep_on_bit};
        poa_pkg::POA_R_CONFIG: next_prdata = {28'h0, config_bits};
        poa_pkg::POA_R_BOOT: next_prdata = {31'h0, boot_status};
        // (RQ21) level code shown beside the state
        poa_pkg::POA_R_STATE: next_prdata = {24'h0, seq_busy, off_lvl, system_reset_out, 1'b0, state};
        poa_pkg::POA_R_CAUSE: next_prdata = {28'h0, swoff_cause};
        poa_pkg::POA_R_FAULT: next_prdata = {30'h0, fault_status};
        poa_pkg::POA_R_PG_MASK: next_prdata = {24'h0, pg_mask};
        poa_pkg::POA_R_INT_STATUS: next_prdata = {29'h0, int_status};
        poa_pkg::POA_R_INT_MASK: next_prdata = {29'h0, int_mask};
        poa_pkg::POA_R_RES_EN: next_prdata = {24'h0, resource_enable};
        default: next_prdata = 32'h0;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking poa_cb @(posedge clk); endclocking
  default disable iff (rst);

  reset_release_a: assert property ($rose(system_reset_out) |-> $past(state) == poa_pkg::POA_S_UP && $past(seq_done)) // (RQ1)
    else $error("reset out released before power-up end");
  on_start_a: assert property (state == poa_pkg::POA_S_OFF && on_request |=> state == poa_pkg::POA_S_UP ##[1:40] system_reset_out) // (RQ2)
    else $error("on request did not reach active");
  window_end_a: assert property (state == poa_pkg::POA_S_ACTIVE && hold_expired && !keep_src && !warm_fall |=> state == poa_pkg::POA_S_DOWN) // (RQ3)
    else $error("hold window end did not shut down");
  hold_fall_a: assert property (state == poa_pkg::POA_S_ACTIVE && !config_bits[0] && $fell(hold_request_pin) && !warm_fall |-> ##1 state == poa_pkg::POA_S_DOWN ##1 swoff_cause[0]) // (RQ5)
    else $error("hold pin fall not taken as off");
  auto_keep_a: assert property (up_done && config_bits[0] && config_bits[1] |=> keep_on_bit && state == poa_pkg::POA_S_ACTIVE) // (RQ6)
    else $error("keep-on bit not set at power-up end");
  boot_latch_a: assert property (up_done |=> boot_status == $past(boot_select_pin)) // (RQ11)
    else $error("selector not latched");
  por_keep_a: assert property (swo_clr && wr_sel == poa_pkg::POA_R_NONE |=> pg_mask == $past(pg_mask) && config_bits == $past(config_bits)) // (RQ14)
    else $error("power-on domain changed by off reset");
  hw_clear_a: assert property (hw_clr |=> int_mask == 3'h0 && !keep_on_bit && resource_enable == 8'h00) // (RQ17)
    else $error("hard reset left domain state");
  swo_only_a: assert property (swo_clr && !hw_clr && wr_sel == poa_pkg::POA_R_NONE |=> int_mask == $past(int_mask) && !keep_on_bit) // (RQ18)
    else $error("switch-off reset touched hardware domain");
  int_low_a: assert property (|(int_status & ~int_mask) && state == poa_pkg::POA_S_ACTIVE |-> !int_n) // (RQ22)
    else $error("pending interrupt not driven low");
  sleep_mask_a: assert property (state == poa_pkg::POA_S_SLEEP && config_bits[3] |-> int_n) // (RQ23)
    else $error("interrupt not masked in sleep");
  warm_up_a: assert property (state == poa_pkg::POA_S_SLEEP && warm_fall |=> state == poa_pkg::POA_S_UP ##[1:40] state == poa_pkg::POA_S_ACTIVE) // (RQ24)
    else $error("warm restart did not return to active");
  timer_off_a: assert property (state == poa_pkg::POA_S_DOWN ##1 state == poa_pkg::POA_S_OFF |=> hold_timer == 28'h0) // (RQ26)
    else $error("hold timer not cleared in off");

  power_up_c: cover property (up_done);
  keep_off_c: cover property (cause_set[1] && state == poa_pkg::POA_S_ACTIVE);
  hard_off_c: cover property (hw_clr);
  sleep_int_c: cover property (state == poa_pkg::POA_S_SLEEP && |int_status);

endmodule : poa_top
`default_nettype wire

/* src/poa_defs.svh */
// offsets, field positions, reset values and timing counts of the power-on acknowledge block
`ifndef POA_DEFS_SVH
`define POA_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define POA_OFF_DEVICE_CONTROL_REGISTER 8'h00
`define POA_OFF_CONFIG 8'h04
`define POA_OFF_BOOT_STATUS 8'h08
`define POA_OFF_STATE 8'h0c
`define POA_OFF_SWOFF_CAUSE 8'h10
`define POA_OFF_FAULT_STATUS 8'h14
`define POA_OFF_PG_MASK 8'h18
`define POA_OFF_INT_STATUS 8'h1c
`define POA_OFF_INT_MASK 8'h20
`define POA_OFF_RES_EN 8'h24

// ****************************************
// field positions and reset values
// ****************************************
`define POA_CFG_KEEPON_MODE 0
`define POA_CFG_AUTO_SET 1
`define POA_CFG_OFF_HARD 2
`define POA_CFG_SLEEP_MASK 3
`define POA_CONFIG_RST 4'ha
`define POA_CAUSE_HOLD 0
`define POA_CAUSE_KEEPON 1
`define POA_CAUSE_TIMEOUT 2
`define POA_CAUSE_THERMAL 3
`define POA_INT_THERMAL 0
`define POA_INT_SHORT 1
`define POA_INT_SEQ_DONE 2
`define POA_INT_W 3
`define POA_RES_W 8
`define POA_SEQ_STEPS 4

// ****************************************
// timing
// ****************************************
`define POA_CLK_HZ 25000000
`define POA_CLK_NS 40
`define POA_HOLD_WINDOW_S 8
`define POA_HOLD_WINDOW_CYCLES (`POA_HOLD_WINDOW_S * `POA_CLK_HZ)
`define POA_SLOT_NS 200
`define POA_SLOT_CYCLES ((`POA_SLOT_NS + `POA_CLK_NS - 1) / `POA_CLK_NS)

`endif

/* src/poa_pkg.sv */
// types of the power-on acknowledge block
`default_nettype none
package poa_pkg;

  typedef enum logic [2:0]
  {
    POA_S_OFF = 3'b000,
    POA_S_UP = 3'b001,
    POA_S_ACTIVE = 3'b010,
    POA_S_SLEEP = 3'b011,
    POA_S_DOWN = 3'b100
  } poa_state_t;

  // reset level codes: lower value clears more domains
  typedef enum logic [1:0]
  {
    POA_LVL_POR = 2'b00,
    POA_LVL_HW = 2'b01,
    POA_LVL_SWO = 2'b10
  } poa_lvl_t;

  typedef enum logic [3:0]
  {
    POA_R_DEVICE_CONTROL_REGISTER = 4'h0,
    POA_R_CONFIG = 4'h1,
    POA_R_BOOT = 4'h2,
    POA_R_STATE = 4'h3,
    POA_R_CAUSE = 4'h4,
    POA_R_FAULT = 4'h5,
    POA_R_PG_MASK = 4'h6,
    POA_R_INT_STATUS = 4'h7,
    POA_R_INT_MASK = 4'h8,
    POA_R_RES_EN = 4'h9,
    POA_R_NONE = 4'hf
  } poa_reg_t;

endpackage : poa_pkg
`default_nettype wire

/* src/poa_seq_runner.sv */
// stored power sequence player: one resource write per slot, branching on the selector
`timescale 1ns/1ps
`default_nettype none
`include "poa_defs.svh"

module poa_seq_runner
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic dir_down,
  input wire logic sel,
  output logic busy,
  output logic done,
  output logic wr_valid,
  output logic [2:0] wr_index,
  output logic wr_value
);

  logic [1:0] step;
  logic [3:0] slot;
  logic down;
  logic [1:0] next_step;
  logic [3:0] next_slot;
  logic next_busy;
  logic next_down;
  logic next_done;
  logic next_wr_valid;
  logic [2:0] next_wr_index;
  logic next_wr_value;

  // slot timer and step walk; selector picks the program half at each step
  always_comb
  begin
    next_step = step;
    next_slot = slot;
    next_busy = busy;
    next_down = down;
    next_done = 1'b0;
    next_wr_valid = 1'b0;
    next_wr_index = wr_index;
    next_wr_value = wr_value;
    if (!busy)
    begin
      if (start)
      begin
        next_busy = 1'b1;
        next_down = dir_down;
        next_step = 2'h0;
        next_slot = 4'h0;
      end
    end
    else if (slot == 4'(`POA_SLOT_CYCLES - 1))
    begin
      next_slot = 4'h0;
      next_wr_valid = 1'b1;
      // (RQ10) selector picks program half
      // down runs the steps in reverse so resources drop in the opposite order
      next_wr_index = {sel, down ? ~step : step};
      next_wr_value = ~down;
      next_step = step + 2'h1;
      if (step == 2'(`POA_SEQ_STEPS - 1))
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
    else
    begin
      next_slot = slot + 4'h1;
    end
  end

  // registers only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      step <= 2'h0;
      slot <= 4'h0;
      busy <= 1'b0;
      down <= 1'b0;
      done <= 1'b0;
      wr_valid <= 1'b0;
      wr_index <= 3'h0;
      wr_value <= 1'b0;
    end
    else
    begin
      step <= next_step;
      slot <= next_slot;
      busy <= next_busy;
      down <= next_down;
      done <= next_done;
      wr_valid <= next_wr_valid;
      wr_index <= next_wr_index;
      wr_value <= next_wr_value;
    end
  end

endmodule : poa_seq_runner
`default_nettype wire

/* test/poa_host_model.sv */
// host processor model that drives the hold request pin
`timescale 1ns/1ps
`default_nettype none

module poa_host_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic keep,
  output logic hold_request_pin
);
  logic next_hold;

  // ****************************************
  // hold pin driver
  // ****************************************
  // pin held high while keep is set
  always_comb next_hold = keep;
  // registered so the pin follows keep one clock later
  always_ff @(posedge clk or posedge rst)
    if (rst)
      hold_request_pin <= 1'b0;
    else
      hold_request_pin <= next_hold;
endmodule : poa_host_model

`default_nettype wire

/* test/tb_top.sv */
// self-checking bench of the power-on acknowledge block
`timescale 1ns/1ps
`default_nettype none
`include "poa_defs.svh"

module tb_top;
  // ****************************************
  // signals, tasks and scenarios
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic on_request = 1'b0;
  logic keep = 1'b0;
  logic boot_select_pin = 1'b0;
  logic warm_n = 1'b1;
  logic sleep_req = 1'b0;
  logic thermal = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hold_request_pin;
  logic system_reset_out;
  logic int_n;
  logic [7:0] resource_enable;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int num_checks = 0;

  // short hold window keeps the run brief
  poa_top #(.HOLD_CYCLES(50)) DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .on_request(on_request), .hold_request_pin(hold_request_pin),
    .warm_restart_pin_n(warm_n), .sleep_request(sleep_req), .boot_select_pin(boot_select_pin),
    .thermal_event(thermal), .short_event(1'b0), .system_reset_out(system_reset_out),
    .int_n(int_n), .resource_enable(resource_enable));
  poa_host_model host (.clk(clk), .rst(rst), .keep(keep), .hold_request_pin(hold_request_pin));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20)
    begin
      chk(1'b0, "no pready");
      tally_and_finish;
    end
    @(posedge clk);
  endtask : apb

  task wait_out(input logic lvl, input int n);
    int i;
    for (i = 0; i < n && system_reset_out !== lvl; i++)
      @(posedge clk);
    if (system_reset_out !== lvl)
    begin
      chk(1'b0, "reset out wait");
      tally_and_finish;
    end
  endtask : wait_out

  // poll the state register until the off sequence has run out
  task wait_off;
    int i;
    rd = 32'h1;
    for (i = 0; i < 12 && rd[2:0] !== 3'h0; i++)
      apb(1'b0, `POA_OFF_STATE, 32'h0);
    if (rd[2:0] !== 3'h0)
    begin
      chk(1'b0, "not off");
      tally_and_finish;
    end
  endtask : wait_off

  task power_up;
    // held until active: a request seen during a down sequence is dropped
    on_request <= 1'b1;
    repeat (6) @(posedge clk);
    chk(system_reset_out === 1'b0, "early release");
    wait_out(1'b1, 100);
    on_request <= 1'b0;
  endtask : power_up

  task s_hold;
    boot_select_pin <= 1'b1;
    keep <= 1'b1;
    power_up;
    apb(1'b0, `POA_OFF_BOOT_STATUS, 32'h0);
    chk(rd[0] === 1'b1, "boot latch");
    apb(1'b0, `POA_OFF_STATE, 32'h0);
    chk(rd[2:0] === 3'h2, "not active");
    chk(resource_enable === 8'hf0, "upper half");
    chk(int_n === 1'b0, "int not low");
    repeat (120) @(posedge clk);
    chk(system_reset_out === 1'b1, "held but off");
    keep <= 1'b0;
    wait_out(1'b0, 100);
    apb(1'b0, `POA_OFF_SWOFF_CAUSE, 32'h0);
    chk(rd[0] === 1'b1, "hold cause");
    apb(1'b0, `POA_OFF_STATE, 32'h0);
    chk(rd[6:5] === 2'h2, "soft level");
    apb(1'b1, `POA_OFF_SWOFF_CAUSE, 32'hf);
  endtask : s_hold

  task s_timeout;
    boot_select_pin <= 1'b0;
    power_up;
    chk(resource_enable === 8'h0f, "lower half");
    repeat (20) @(posedge clk);
    chk(system_reset_out === 1'b1, "window short");
    wait_out(1'b0, 200);
    apb(1'b0, `POA_OFF_SWOFF_CAUSE, 32'h0);
    chk(rd[2] === 1'b1, "timeout cause");
    apb(1'b0, `POA_OFF_BOOT_STATUS, 32'h0);
    chk(rd[0] === 1'b0, "boot latch low");
    apb(1'b1, `POA_OFF_SWOFF_CAUSE, 32'hf);
  endtask : s_timeout

  task s_auto;
    apb(1'b1, `POA_OFF_CONFIG, 32'h7);
    power_up;
    apb(1'b0, `POA_OFF_DEVICE_CONTROL_REGISTER, 32'h0);
    chk(rd[0] === 1'b1, "keep bit unset");
    apb(1'b1, `POA_OFF_INT_MASK, 32'h5);
    chk(int_n === 1'b1, "mask ignored");
    apb(1'b1, `POA_OFF_DEVICE_CONTROL_REGISTER, 32'h0);
    wait_out(1'b0, 100);
    wait_off;
    chk(resource_enable === 8'h00, "enables left on");
    apb(1'b0, `POA_OFF_SWOFF_CAUSE, 32'h0);
    chk(rd[1] === 1'b1, "keep cause");
    apb(1'b0, `POA_OFF_INT_MASK, 32'h0);
    chk(rd === 32'h0, "hw kept");
    apb(1'b0, `POA_OFF_CONFIG, 32'h0);
    chk(rd === 32'h7, "config lost");
    apb(1'b0, `POA_OFF_STATE, 32'h0);
    chk(rd[6:5] === 2'h1, "hard level");
  endtask : s_auto

  // keep-on bit by hand, sleep masking, warm restart, thermal off
  task s_warm;
    apb(1'b1, `POA_OFF_CONFIG, 32'h9);
    power_up;
    apb(1'b0, `POA_OFF_DEVICE_CONTROL_REGISTER, 32'h0);
    chk(rd[0] === 1'b0, "bit set without auto");
    apb(1'b1, `POA_OFF_DEVICE_CONTROL_REGISTER, 32'h1);
    sleep_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk(int_n === 1'b1, "int in sleep");
    warm_n <= 1'b0;
    sleep_req <= 1'b0;
    @(posedge clk);
    warm_n <= 1'b1;
    wait_out(1'b0, 4);
    wait_out(1'b1, 100);
    apb(1'b0, `POA_OFF_STATE, 32'h0);
    chk(rd[2:0] === 3'h2, "warm not active");
    thermal <= 1'b1;
    @(posedge clk);
    thermal <= 1'b0;
    wait_off;
    apb(1'b0, `POA_OFF_FAULT_STATUS, 32'h0);
    chk(rd[1:0] === 2'h1, "thermal fault");
    apb(1'b0, `POA_OFF_STATE, 32'h0);
    chk(rd[6:5] === 2'h1, "thermal not hard");
  endtask : s_warm

  // main sequence: reset, register defaults, then the off paths
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `POA_OFF_CONFIG, 32'h0);
    chk(rd === {28'h0, `POA_CONFIG_RST}, "config reset");
    apb(1'b0, 8'h30, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped");
    s_hold;
    s_timeout;
    s_warm;
    s_auto;
    tally_and_finish;
  end
endmodule : tb_top

`default_nettype wire
